// *** shared/can_timing_defs.svh ***
`ifndef CAN_TIMING_DEFS_SVH
`define CAN_TIMING_DEFS_SVH

// register map (byte addresses)
`define BTC_ADDR       4'h0
`define CTL_ADDR       4'h4
`define STAT_ADDR      4'h8

// timing register fields
`define QDIV_LSB       0
`define QDIV_MSB       5
`define JW_LSB         6
`define JW_MSB         7
`define SEG1_LSB       8
`define SEG1_MSB       11
`define SEG2_LSB       12
`define SEG2_MSB       14
`define BTC_USED_MASK  16'h7FFF

// reset values
`define BTC_RESET      16'h0000
`define HALT_RESET     1'b1

`endif

// *** shared/can_timing_pkg.sv ***
package can_timing_pkg;

   typedef enum logic [1:0] {
      SEG_SYNC,
      SEG_ONE,
      SEG_TWO
   } seg_t;

   typedef logic [15:0] timing_word_t;

endpackage : can_timing_pkg

// *** src/tq_divider.sv ***
`timescale 1ns/1ps
`include "can_timing_defs.svh"

module tq_divider
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       run,
   input  wire logic [5:0] quantum_divider,
   // quantum tick
   output logic            tq_tick
);

   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic       wrap;

   // a quantum is quantum_divider+1 clocks; halt restarts the count
   assign wrap  = (cnt_q == quantum_divider);
   assign cnt_d = (!run || wrap) ? 6'h00 : cnt_q + 6'h01;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_q   <= 6'h00;
         tq_tick <= 1'b0;
      end
      else
      begin
         cnt_q   <= cnt_d;
         tq_tick <= run && wrap;
      end
   end

endmodule : tq_divider

// *** src/can_bit_timing.sv ***
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "can_timing_defs.svh"

// Summary of operation
// - quantum lasts quantum_divider plus one system clocks
// - jump width is field plus one quanta
// - segment one is field plus one quanta, propagation and phase one
// - segment two is field plus one quanta, equal to phase two
// - bit time is sync quantum plus segment one plus segment two
// - bit time is adjusted in segment one and segment two to follow bus edges
// - segment one absorbs delay, phase segments absorb oscillator error
module can_bit_timing
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // can bus receive level
   input  wire logic        bus_rx,
   // timing outputs
   output logic             halt_q,
   output logic             time_quantum,
   output logic             bit_start,
   output logic             sample_point,
   output logic             sampled_bit
);
   import can_timing_pkg::*;

   // ==========================================================
   // register bus
   // ==========================================================
   timing_word_t btc_q;
   timing_word_t btc_d;
   timing_word_t act_q;
   logic         halt_d;
   logic         req;
   logic         wr;
   logic         sel_btc;
   logic         sel_ctl;
   logic         sel_stat;
   logic [31:0]  rd_d;

   assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign sel_btc  = (wb_adr_i == `BTC_ADDR);
   assign sel_ctl  = (wb_adr_i == `CTL_ADDR);
   assign sel_stat = (wb_adr_i == `STAT_ADDR);

   // timing register writes only land while halted, so the running bit never tears
   assign btc_d[7:0]  = (wr && sel_btc && halt_q && wb_sel_i[0])
                        ? wb_dat_i[7:0] : btc_q[7:0];
   assign btc_d[15:8] = (wr && sel_btc && halt_q && wb_sel_i[1])
                        ? (wb_dat_i[15:8] & 8'(`BTC_USED_MASK >> 8))
                        : btc_q[15:8];
   assign halt_d = (wr && sel_ctl && wb_sel_i[0]) ? wb_dat_i[0] : halt_q;

   logic [1:0] seg_code;
   logic [3:0] qcnt_q;

   assign rd_d = sel_btc  ? {16'h0000, btc_q} :
                 sel_ctl  ? {31'h00000000, halt_q} :
                 sel_stat ? {24'h000000, sampled_bit, seg_code, 1'b0,
                             qcnt_q} :
                 32'h00000000;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         btc_q    <= `BTC_RESET;
         halt_q   <= `HALT_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         btc_q    <= btc_d;
         halt_q   <= halt_d;
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_d : wb_dat_o;
      end
   end

   // ==========================================================
   // active timing, latched on halt release
   // ==========================================================
   always_ff @(posedge clk)
   begin
      if (rst)
         act_q <= `BTC_RESET;
      else if (halt_q)
         act_q <= btc_q;
   end

   logic [5:0] qdiv;
   logic [3:0] jw;
   logic [3:0] seg2_len;
   logic [4:0] seg1_full;

   assign qdiv      = act_q[`QDIV_MSB:`QDIV_LSB];
   assign jw        = {2'b00, act_q[`JW_MSB:`JW_LSB]} + 4'h1;
   assign seg1_full = {1'b0, act_q[`SEG1_MSB:`SEG1_LSB]} + 5'h01;
   assign seg2_len  = {1'b0, act_q[`SEG2_MSB:`SEG2_LSB]} + 4'h1;

   // ==========================================================
   // quantum generation
   // ==========================================================
   logic tq;

   tq_divider u_div
   (
      .clk             (clk),
      .rst             (rst),
      .run             (!halt_q),
      .quantum_divider (qdiv),
      .tq_tick         (tq)
   );

   // ==========================================================
   // bit segment sequencer
   // ==========================================================
   seg_t       seg_q;
   seg_t       seg_d;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic [4:0] lim_q;
   logic [4:0] lim_d;
   logic       rx_q;
   logic       edge_seen;
   logic [4:0] ext;
   logic       seg_end;

   assign seg_code  = seg_q;
   assign qcnt_q    = cnt_q[3:0];
   assign edge_seen = rx_q && !bus_rx;

   // phase error clipped to the jump width
   function automatic logic [4:0] clip(input logic [4:0] v,
                                       input logic [3:0] m);
      clip = (v > {1'b0, m}) ? {1'b0, m} : v;
   endfunction : clip

   // late edge in segment one lengthens it; early edge in two shortens
   assign ext = clip(cnt_q + 5'h01, jw);
   assign seg_end = tq && (cnt_q + 5'h01 >= lim_q);

   always_comb
   begin
      seg_d = seg_q;
      cnt_d = cnt_q;
      lim_d = lim_q;
      if (halt_q)
      begin
         seg_d = SEG_SYNC;
         cnt_d = 5'h00;
         lim_d = 5'h01;
      end
      else if (tq && edge_seen && seg_q == SEG_ONE)
      begin
         lim_d = lim_q + ext;
         cnt_d = cnt_q + 5'h01;
      end
      else if (tq && edge_seen && seg_q == SEG_TWO &&
               (lim_q - cnt_q) <= {1'b0, jw})
      begin
         // edge early, cut segment two and restart bit
         seg_d = SEG_ONE;
         cnt_d = 5'h00;
         lim_d = seg1_full;
      end
      else if (seg_end)
      begin
         cnt_d = 5'h00;
         unique case (seg_q)
            SEG_SYNC:
            begin
               seg_d = SEG_ONE;
               lim_d = seg1_full;
            end
            SEG_ONE:
            begin
               seg_d = SEG_TWO;
               lim_d = {1'b0, seg2_len};
            end
            SEG_TWO:
            begin
               seg_d = SEG_SYNC;
               lim_d = 5'h01;
            end
            default: seg_d = SEG_SYNC;
         endcase
      end
      else if (tq)
         cnt_d = cnt_q + 5'h01;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         seg_q        <= SEG_SYNC;
         cnt_q        <= 5'h00;
         lim_q        <= 5'h01;
         rx_q         <= 1'b1;
         time_quantum <= 1'b0;
         bit_start    <= 1'b0;
         sample_point <= 1'b0;
         sampled_bit  <= 1'b1;
      end
      else
      begin
         seg_q        <= seg_d;
         cnt_q        <= cnt_d;
         lim_q        <= lim_d;
         rx_q         <= tq ? bus_rx : rx_q;
         time_quantum <= tq;
         bit_start    <= !halt_q && seg_q == SEG_TWO && seg_d != SEG_TWO;
         sample_point <= seg_q == SEG_ONE && seg_d == SEG_TWO;
         if (seg_q == SEG_ONE && seg_d == SEG_TWO)
            sampled_bit <= bus_rx;
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   property p_no_write_running;
      @(posedge clk) disable iff (rst)
      !halt_q |=> $stable(btc_q);
   endproperty
   a_no_write_running: assert property (p_no_write_running)
      else $error("timing register changed while running");

   property p_bit15_zero;
      @(posedge clk) disable iff (rst)
      btc_q[15] == 1'b0;
   endproperty
   a_bit15_zero: assert property (p_bit15_zero)
      else $error("unused timing bit set");

   property p_quantum_spacing;
      @(posedge clk) disable iff (rst || halt_q)
      (tq && qdiv == 6'h01) |=> !tq ##1 tq;
   endproperty
   a_quantum_spacing: assert property (p_quantum_spacing)
      else $error("quantum spacing wrong");

   property p_halt_no_tq;
      @(posedge clk) disable iff (rst)
      halt_q |=> !tq;
   endproperty
   a_halt_no_tq: assert property (p_halt_no_tq)
      else $error("quantum ticked during halt");

   property p_sync_one_tq;
      @(posedge clk) disable iff (rst || halt_q)
      (seg_q == SEG_SYNC && tq) |=> seg_q == SEG_ONE;
   endproperty
   a_sync_one_tq: assert property (p_sync_one_tq)
      else $error("sync segment not one quantum");

   property p_seg2_len;
      @(posedge clk) disable iff (rst || halt_q)
      (seg_q == SEG_ONE && seg_d == SEG_TWO) |=>
         lim_q == {1'b0, seg2_len};
   endproperty
   a_seg2_len: assert property (p_seg2_len)
      else $error("segment two length wrong");

   property p_sample_after_seg1;
      @(posedge clk) disable iff (rst)
      sample_point |-> seg_q == SEG_TWO;
   endproperty
   a_sample_after_seg1: assert property (p_sample_after_seg1)
      else $error("sample point misplaced");

   property p_jump_bound;
      @(posedge clk) disable iff (rst || halt_q)
      (seg_q == SEG_ONE && seg_d == SEG_ONE) |=>
         lim_q <= seg1_full + {1'b0, jw};
   endproperty
   a_jump_bound: assert property (p_jump_bound)
      else $error("resync exceeded jump width");

endmodule : can_bit_timing

// *** verification/can_bus_model.sv ***
`timescale 1ns/1ps
// ==========================================
// far-side bus: wired-and, recessive 1 when nobody pulls it
module can_bus_model
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // bench asks for a dominant level
   input  wire logic dominant,
   // level seen by the node
   output logic      bus_rx
);
   // one flop of line delay, pull-up to recessive in reset
   always_ff @(posedge clk)
      bus_rx <= rst ? 1'b1 : ~dominant;
endmodule : can_bus_model

// *** verification/test_can_bit_timing.sv ***
`timescale 1ns/1ps
`include "can_timing_defs.svh"
module test_can_bit_timing;
   import can_timing_pkg::*;
   logic        clk, rst, cyc, stb, we, dom, rx, ack;
   logic        halt, tq, bs, sp, sbit;
   logic [3:0]  adr;
   logic [31:0] wdat, rdat, r;
   logic [15:0] cfg [4];
   int num_errors, cmp_count, cyc_n, tq_last, tq_gap, tq_n;
   int bs_last, bs_gap, sp_last, sp_to_bs, q, bt, s2, n;
   can_bit_timing u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .bus_rx(rx),
      .halt_q(halt), .time_quantum(tq), .bit_start(bs),
      .sample_point(sp), .sampled_bit(sbit));
   can_bus_model u_bus (.clk(clk), .rst(rst), .dominant(dom), .bus_rx(rx));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ==========================================
   // pulse spacing monitor and hang guard
   always @(posedge clk)
   begin
      cyc_n <= cyc_n + 1;
      if (tq === 1'b1)
      begin
         tq_gap  <= cyc_n - tq_last;
         tq_last <= cyc_n;
         tq_n    <= tq_n + 1;
      end
      if (sp === 1'b1)
         sp_last <= cyc_n;
      if (bs === 1'b1)
      begin
         bs_gap   <= cyc_n - bs_last;
         bs_last  <= cyc_n;
         sp_to_bs <= cyc_n - sp_last;
      end
      if (cyc_n == 60000)
      begin
         num_errors++;
         report_and_stop;
      end
   end
   task report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // ==========================================
   // classic wishbone single cycle
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      check(nm, r, e);
   endtask : rd
   // ==========================================
   // main sequence
   initial
   begin
      rst  = 1'b1;
      cyc  = 1'b0;
      stb  = 1'b0;
      we   = 1'b0;
      adr  = 4'h0;
      wdat = 32'h0;
      dom  = 1'b0;
      cfg  = '{16'h0100, 16'hFFFF, 16'h2341, 16'h2342};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      check("halt", {31'h0, halt}, 32'h1);
      rd(`BTC_ADDR, 32'h0, "timing reset");
      rd(`STAT_ADDR, 32'h80, "status idle");
      wb(1'b1, 4'hC, 32'hFFFF_FFFF);
      rd(4'hC, 32'h0, "unmapped");
      for (int i = 0; i < 4; i++)
      begin
         q  = cfg[i][5:0] + 1;
         s2 = (cfg[i][14:12] + 1) * q;
         bt = (3 + cfg[i][11:8] + cfg[i][14:12]) * q;
         wb(1'b1, `CTL_ADDR, 32'h1);
         wb(1'b1, `BTC_ADDR, {16'h0, cfg[i]});
         rd(`BTC_ADDR, {17'h0, cfg[i][14:0]}, "timing");
         n = tq_n;
         repeat (20) @(posedge clk);
         check("quanta halted", 32'(tq_n - n), 32'h0);
         wb(1'b1, `CTL_ADDR, 32'h0);
         repeat (2 * bt + 2 * q + 20) @(posedge clk);
         check("quantum gap", 32'(tq_gap), 32'(q));
         check("bit gap", 32'(bs_gap), 32'(bt));
         check("sample to end", 32'(sp_to_bs), 32'(s2));
         // running write must not disturb the active timing
         wb(1'b1, `BTC_ADDR, 32'h0);
         rd(`BTC_ADDR, {17'h0, cfg[i][14:0]}, "locked");
         repeat (bt + 5) @(posedge clk);
         check("bit gap held", 32'(bs_gap), 32'(bt));
         $display("test %0d done", i);
      end
      // falling edge in the third quantum of segment one: lengthened by jump width
      do @(posedge clk); while (bs !== 1'b1);
      repeat (9) @(posedge clk);
      dom <= 1'b1;
      do @(posedge clk); while (bs !== 1'b1);
      @(posedge clk);
      check("resync gap", 32'(bs_gap), 32'(bt + 2 * q));
      check("sampled", {31'h0, sbit}, 32'h0);
      dom <= 1'b0;
      wb(1'b1, `CTL_ADDR, 32'h1);
      rd(`STAT_ADDR, 32'h0, "status halted");
      $display("test resync done");
      report_and_stop;
   end
endmodule : test_can_bit_timing
